// ### hw/aums_params.svh
`ifndef AUMS_PARAMS_SVH
`define AUMS_PARAMS_SVH

// Register byte offsets.
`define AUMS_OFF_STATUS 12'h104
`define AUMS_OFF_MASK 12'h108
`define AUMS_OFF_SEVERITY 12'h10C
`define AUMS_OFF_CTRL 12'h180
`define AUMS_ADDR_W 12

// Error type bit positions.
`define AUMS_BIT_LEGACY 0
`define AUMS_BIT_LINK_PROTO 4
`define AUMS_BIT_SURPRISE_DOWN 5
`define AUMS_BIT_POISONED 12
`define AUMS_BIT_FLOW_CTRL 13
`define AUMS_BIT_INTERNAL 22
`define AUMS_BIT_MCAST_BLOCKED 23

// Control register bit positions.
`define AUMS_CTRL_INT_REPORT_EN 0
`define AUMS_CTRL_MCAST_DISABLE 1

// Implemented bits and reset values.
`define AUMS_EVT_BITS 32'h00C03030
`define AUMS_MASK_BITS 32'h00C00000
`define AUMS_MASK_RESET 32'h00400000
`define AUMS_SEV_BITS 32'h00003031
`define AUMS_SEV_RESET 32'h00002030
`define AUMS_CTRL_BITS 32'h00000003
`define AUMS_CTRL_RESET 32'h00000001
`define AUMS_ZERO32 32'h00000000
`define AUMS_FEP_W 5

`endif

// ### hw/aums_pkg.sv
package aums_pkg;

    typedef struct packed {
        logic [31:0] status;
        logic [31:0] mask;
        logic [31:0] sev;
        logic [31:0] ctrl;
        logic [4:0] fep;
        logic fep_vld;
        logic fep_upd;
        logic log_evt;
        logic fatal;
        logic nonfatal;
        logic ack;
        logic [31:0] dat;
    } aums_state_t;

endpackage

// ### hw/aums_top.sv
// The Wishbone interface to the registers was decided locally.
`timescale 1ns/10ps
`include "aums_params.svh"

// Contract
// RULE1: Masked internal/multicast errors: no log, pointer, report.
// RULE2: Mask bits never alter uncorrectable status bits.
// RULE3: Mask 22 resets one, 23 zero; sticky.
// RULE4: Internal report disabled: mask 22 reads zero, read-only.
// RULE5: Multicast report disabled: mask 23 reads zero, read-only.
// RULE6: Severity one reports fatal, zero non-fatal.
// RULE7: Severity 4,5,13 reset one; 12 resets zero.
// RULE8: Severity bit 0 stored, sticky, no effect.
// RULE9: Severity register decoded at offset 0x10C.
// RULE10: Sticky bits survive hot reset, cleared by fundamental.
module aums_top
    import aums_pkg::*;
(
    input wire logic clk_i, // 125 MHz clock.
    input wire logic rst_i, // Fundamental reset, synchronous, active high.
    input wire logic hot_rst_i, // Hot or link reset, clears only non-sticky state.
    input wire logic wb_cyc_i, // Wishbone cycle.
    input wire logic wb_stb_i, // Wishbone strobe.
    input wire logic wb_we_i, // Wishbone write enable.
    input wire logic [11:0] wb_adr_i, // Wishbone byte address.
    input wire logic [3:0] wb_sel_i, // Wishbone byte selects.
    input wire logic [31:0] wb_dat_i, // Wishbone write data.
    output logic [31:0] wb_dat_o, // Wishbone read data.
    output logic wb_ack_o, // Wishbone acknowledge.
    input wire logic [31:0] evt_i, // One-cycle error event pulses by type bit.
    input wire logic [1:0] upper_sev_i, // Severity of internal (0) and multicast (1) errors.
    output logic log_o, // Pulse: an unmasked event was logged.
    output logic fatal_o, // Pulse: fatal error message requested.
    output logic nonfatal_o, // Pulse: non-fatal error message requested.
    output logic fep_upd_o, // Pulse: first error pointer was loaded.
    output logic [4:0] fep_o, // First error pointer.
    output logic [31:0] status_o // Uncorrectable status bits.
);

    aums_state_t st_r;
    aums_state_t st_nxt;

    // Expands byte selects into a bit mask.
    function automatic logic [31:0] byte_mask(input logic [3:0] sel);
        logic [31:0] m;
        m = `AUMS_ZERO32;
        for (int i = 0; i < 4; i++) begin
            m[i*8 +: 8] = {8{sel[i]}};
        end
        return m;
    endfunction

    // Lowest set bit index, used for the first error pointer.
    function automatic logic [4:0] low_idx(input logic [31:0] v);
        logic [4:0] r;
        r = 5'h00;
        for (int i = 31; i >= 0; i--) begin
            if (v[i]) begin
                r = 5'(i);
            end
        end
        return r;
    endfunction

    // Mask bits as seen by software and by the logging path.
    function automatic logic [31:0] eff_mask(input logic [31:0] mask, input logic [31:0] ctrl);
        logic [31:0] m;
        m = mask & `AUMS_MASK_BITS;
        if (!ctrl[`AUMS_CTRL_INT_REPORT_EN]) begin
            m[`AUMS_BIT_INTERNAL] = 1'b0; // [RULE4]
        end
        if (ctrl[`AUMS_CTRL_MCAST_DISABLE]) begin
            m[`AUMS_BIT_MCAST_BLOCKED] = 1'b0; // [RULE5]
        end
        return m;
    endfunction

    // Read-modify-write of the implemented bits that the byte selects cover.
    function automatic logic [31:0] merge_wr(
        input logic [31:0] old,
        input logic [31:0] wdat,
        input logic [31:0] sel_m,
        input logic [31:0] impl
    );
        logic [31:0] keep;
        keep = sel_m & impl;
        return (old & ~keep) | (wdat & keep);
    endfunction

    // True when the mask bit at index i may be written under the current controls.
    function automatic logic eff_lock_free(input int i, input logic [31:0] ctrl);
        logic ok;
        ok = 1'b1;
        if (i == `AUMS_BIT_INTERNAL && !ctrl[`AUMS_CTRL_INT_REPORT_EN]) begin
            ok = 1'b0;
        end
        if (i == `AUMS_BIT_MCAST_BLOCKED && ctrl[`AUMS_CTRL_MCAST_DISABLE]) begin
            ok = 1'b0;
        end
        return ok;
    endfunction

    logic req;
    logic [31:0] wmask;
    logic [31:0] ev;
    logic [31:0] unm;
    logic [31:0] sev_all;
    logic [31:0] clr;
    logic [31:0] rd;

    always_comb begin
        st_nxt = st_r;
        req = wb_cyc_i && wb_stb_i;
        wmask = byte_mask(wb_sel_i);
        ev = evt_i & `AUMS_EVT_BITS;
        clr = `AUMS_ZERO32;
        st_nxt.fep_upd = 1'b0;
        st_nxt.log_evt = 1'b0;
        st_nxt.fatal = 1'b0;
        st_nxt.nonfatal = 1'b0;

        // Bus answer: ack one cycle after the request, data captured with it.
        st_nxt.ack = req && !st_r.ack;
        rd = `AUMS_ZERO32;
        unique case (wb_adr_i)
            `AUMS_OFF_STATUS: begin
                rd = st_r.status;
            end
            `AUMS_OFF_MASK: begin
                rd = eff_mask(st_r.mask, st_r.ctrl); // [RULE4] [RULE5]
            end
            `AUMS_OFF_SEVERITY: begin
                rd = st_r.sev & `AUMS_SEV_BITS; // [RULE9]
            end
            `AUMS_OFF_CTRL: begin
                rd = st_r.ctrl & `AUMS_CTRL_BITS;
            end
            default: begin
                rd = `AUMS_ZERO32;
            end
        endcase
        if (req && !st_r.ack) begin
            st_nxt.dat = rd;
        end

        // Writes take effect at the edge that ends the ack cycle, one edge after ack is presented to the master.
        if (req && st_r.ack && wb_we_i) begin
            unique case (wb_adr_i)
                `AUMS_OFF_STATUS: begin
                    clr = wb_dat_i & wmask & `AUMS_EVT_BITS;
                end
                `AUMS_OFF_MASK: begin
                    // Only the mask field is written; status stays untouched.
                    for (int i = `AUMS_BIT_INTERNAL; i <= `AUMS_BIT_MCAST_BLOCKED; i++) begin
                        if (wmask[i] && eff_lock_free(i, st_r.ctrl)) begin
                            st_nxt.mask[i] = wb_dat_i[i]; // [RULE2] [RULE4] [RULE5]
                        end
                    end
                end
                `AUMS_OFF_SEVERITY: begin
                    st_nxt.sev = merge_wr(st_r.sev, wb_dat_i, wmask, `AUMS_SEV_BITS); // [RULE8] [RULE9]
                end
                `AUMS_OFF_CTRL: begin
                    st_nxt.ctrl = merge_wr(st_r.ctrl, wb_dat_i, wmask, `AUMS_CTRL_BITS);
                end
                default: begin
                    clr = `AUMS_ZERO32;
                end
            endcase
        end

        // Status records every event whatever the mask; a set beats a clear.
        st_nxt.status = (st_r.status & ~clr) | ev; // [RULE2]

        // Disabled reporting paths behave as suppressed for logging too.
        unm = ev & ~eff_mask(st_r.mask, st_r.ctrl); // [RULE1]
        if (!st_r.ctrl[`AUMS_CTRL_INT_REPORT_EN]) begin
            unm[`AUMS_BIT_INTERNAL] = 1'b0;
        end
        if (st_r.ctrl[`AUMS_CTRL_MCAST_DISABLE]) begin
            unm[`AUMS_BIT_MCAST_BLOCKED] = 1'b0;
        end

        // Legacy bit 0 is stored only; it never takes part in reporting.
        sev_all = st_r.sev & `AUMS_SEV_BITS;
        sev_all[`AUMS_BIT_LEGACY] = 1'b0; // [RULE8]
        sev_all[`AUMS_BIT_INTERNAL] = upper_sev_i[0];
        sev_all[`AUMS_BIT_MCAST_BLOCKED] = upper_sev_i[1];

        st_nxt.log_evt = |unm; // [RULE1]
        st_nxt.fatal = |(unm & sev_all); // [RULE6]
        st_nxt.nonfatal = |(unm & ~sev_all); // [RULE6]

        // The pointer is released when software clears the status bit it names.
        if (st_r.fep_vld && clr[st_r.fep] && !ev[st_r.fep]) begin
            st_nxt.fep_vld = 1'b0;
        end
        if (!st_r.fep_vld && (|unm)) begin
            st_nxt.fep = low_idx(unm); // [RULE1]
            st_nxt.fep_vld = 1'b1;
            st_nxt.fep_upd = 1'b1;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            st_r.status <= `AUMS_ZERO32;
            st_r.mask <= `AUMS_MASK_RESET; // [RULE3]
            st_r.sev <= `AUMS_SEV_RESET; // [RULE7] [RULE8]
            st_r.ctrl <= `AUMS_CTRL_RESET;
            st_r.fep <= 5'h00;
            st_r.fep_vld <= 1'b0;
            st_r.fep_upd <= 1'b0;
            st_r.log_evt <= 1'b0;
            st_r.fatal <= 1'b0;
            st_r.nonfatal <= 1'b0;
            st_r.ack <= 1'b0;
            st_r.dat <= `AUMS_ZERO32;
        end else if (hot_rst_i) begin
            // Sticky status, mask, severity and pointer are kept.
            st_r.status <= st_r.status; // [RULE10]
            st_r.mask <= st_r.mask; // [RULE10]
            st_r.sev <= st_r.sev; // [RULE10]
            st_r.ctrl <= `AUMS_CTRL_RESET;
            st_r.fep <= st_r.fep;
            st_r.fep_vld <= st_r.fep_vld;
            st_r.fep_upd <= 1'b0;
            st_r.log_evt <= 1'b0;
            st_r.fatal <= 1'b0;
            st_r.nonfatal <= 1'b0;
            st_r.ack <= 1'b0;
            st_r.dat <= `AUMS_ZERO32;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign wb_dat_o = st_r.dat;
    assign wb_ack_o = st_r.ack;
    assign log_o = st_r.log_evt;
    assign fatal_o = st_r.fatal;
    assign nonfatal_o = st_r.nonfatal;
    assign fep_upd_o = st_r.fep_upd;
    assign fep_o = st_r.fep;
    assign status_o = st_r.status;

endmodule

// ### tb/aums_chk_sva.sv
`timescale 1ns/10ps
module aums_chk (
    input wire logic clk_i, rst_i, hot_rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, // Clock, resets, bus.
    input wire logic log_o, fatal_o, nonfatal_o, fep_upd_o, // Report pulses.
    input wire logic [11:0] wb_adr_i, // Bus address.
    input wire logic [3:0] wb_sel_i, // Bus byte selects.
    input wire logic [31:0] wb_dat_i, wb_dat_o, evt_i, status_o, // Data, events, status.
    input wire logic [1:0] upper_sev_i, // Upper severities.
    input wire logic [4:0] fep_o // First error pointer.
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    chk_ack_once: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o && !hot_rst_i |=> wb_ack_o)
        else $error("request not acknowledged");
    chk_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack longer than one cycle");
    chk_sev_reserved: assert property (wb_ack_o && !wb_we_i && wb_adr_i == 12'h10C |-> (wb_dat_o & 32'hFFFFCFCE) == 32'h0)
        else $error("severity reserved bits set");
    chk_status_kept: assert property (evt_i[22] && !hot_rst_i |=> status_o[22])
        else $error("status not set by event");
    chk_log_cause: assert property (log_o |-> $past(|(evt_i & 32'h00C03030)))
        else $error("log without event");
    chk_mc_fatal: assert property (evt_i == 32'h00800000 && upper_sev_i[1] |=> !nonfatal_o)
        else $error("fatal multicast reported non-fatal");
    chk_ie_nonfatal: assert property (evt_i == 32'h00400000 && !upper_sev_i[0] |=> !fatal_o)
        else $error("non-fatal internal reported fatal");
    chk_report_logged: assert property (fatal_o || nonfatal_o |-> log_o)
        else $error("report without log");
    chk_fep_points: assert property (fep_upd_o |-> status_o[fep_o] && log_o)
        else $error("pointer load not tied to logged status");
    cover property (fatal_o);
    cover property (nonfatal_o);
    cover property (fep_upd_o);
endmodule

bind aums_top aums_chk aums_chk_i (.*);

// ### tb/tb_top.sv
`timescale 1ns/10ps
module tb_top;
    logic clk_i = 1'b0, rst_i = 1'b1, hot_rst_i = 1'b0, wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
    logic [11:0] wb_adr_i = 12'h0;
    logic [3:0] wb_sel_i = 4'hF;
    logic [31:0] wb_dat_i = 32'h0, evt_i = 32'h0, wb_dat_o, status_o;
    logic [1:0] upper_sev_i = 2'h1;
    logic wb_ack_o, log_o, fatal_o, nonfatal_o, fep_upd_o;
    logic [4:0] fep_o;
    int mismatches = 0, checks = 0, cycles = 0;
    int bits[4] = '{4, 5, 12, 13};

    aums_top aums_top_i (.*);

    always #4 clk_i = ~clk_i;

    task automatic complete_run();
        if (mismatches == 0 && checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    always @(posedge clk_i) begin
        cycles++;
        if (cycles == 3000) begin
            mismatches++;
            complete_run();
        end
    end

    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            mismatches++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic bus(input logic [11:0] a, input logic we, input logic [31:0] d, output logic [31:0] q);
        @(posedge clk_i);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= a;
        wb_dat_i <= d;
        do @(posedge clk_i); while (wb_ack_o !== 1'b1);
        q = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] q;
        bus(a, 1'b1, d, q);
    endtask

    task automatic rd(input logic [11:0] a, input logic [31:0] exp);
        logic [31:0] q;
        bus(a, 1'b0, 32'h0, q);
        cmp(q, exp);
    endtask

    // Pulses one event and compares log, fatal, non-fatal and status one cycle later.
    task automatic ev(input int b, input logic [3:0] e);
        @(posedge clk_i) evt_i <= 32'h1 << b;
        @(posedge clk_i) evt_i <= 32'h0;
        @(posedge clk_i);
        cmp({28'h0, log_o, fatal_o, nonfatal_o, status_o[b]}, {28'h0, e});
    endtask

    initial begin
        repeat (3) @(posedge clk_i);
        rst_i <= 1'b0;
        rd(12'h108, 32'h00400000);
        rd(12'h10C, 32'h00002030);
        foreach (bits[i]) ev(bits[i], (bits[i] == 12) ? 4'hB : 4'hD);
        cmp({27'h0, fep_o}, 32'h4);
        ev(22, 4'h1);
        ev(23, 4'hB);
        wr(12'h108, 32'h00800000);
        cmp(status_o, 32'h00C03030);
        wr(12'h104, 32'hFFFFFFFF);
        rd(12'h108, 32'h00800000);
        upper_sev_i <= 2'h2;
        ev(23, 4'h1);
        ev(22, 4'hB);
        cmp({27'h0, fep_o}, 32'h16);
        wr(12'h10C, 32'h1);
        rd(12'h10C, 32'h1);
        ev(4, 4'hB);
        wr(12'h180, 32'h2);
        rd(12'h108, 32'h0);
        wr(12'h108, 32'h00400000);
        wr(12'h180, 32'h1);
        rd(12'h108, 32'h00800000);
        @(posedge clk_i) hot_rst_i <= 1'b1;
        @(posedge clk_i) hot_rst_i <= 1'b0;
        rd(12'h10C, 32'h1);
        rd(12'h108, 32'h00800000);
        rd(12'h104, 32'h00C00010);
        rd(12'h0F0, 32'h0);
        @(posedge clk_i) rst_i <= 1'b1;
        @(posedge clk_i) rst_i <= 1'b0;
        rd(12'h10C, 32'h00002030);
        rd(12'h104, 32'h0);
        complete_run();
    end
endmodule
